//--- src/adsp_regs.vh
`ifndef ADSP_REGS_VH
`define ADSP_REGS_VH
// clock and time base
`define ADSP_CLK_NS          20
`define ADSP_TCY_NS          40
`define ADSP_TCY_CLKS        ((`ADSP_TCY_NS + `ADSP_CLK_NS - 1) / `ADSP_CLK_NS)
`define ADSP_RC_TAD_NS       200
`define ADSP_RC_TAD_CLKS     ((`ADSP_RC_TAD_NS + `ADSP_CLK_NS - 1) / `ADSP_CLK_NS)
// sequence lengths in converter clock periods
`define ADSP_CONV_TADS       5'h0C
`define ADSP_MIN_SAMPLE_TADS 5'h01
`define ADSP_WAKE_WAIT_TADS  5'h02
// trigger source codes
`define ADSP_TRIG_MANUAL     3'h0
`define ADSP_TRIG_AUTO       3'h7
// sample-and-hold channel count codes
`define ADSP_SAMPLE_HOLD_CHANNEL_COUNT_ONE        2'h0
`define ADSP_SAMPLE_HOLD_CHANNEL_COUNT_TWO        2'h1
// data path
`define ADSP_DATA_W          10
`define ADSP_FIFO_W          12
`define ADSP_FIFO_DEPTH      8
`define ADSP_FIFO_AW         3
// reset values
`define ADSP_RESULT_RST      10'h000
`endif

//--- src/adsp_fifo.v
`default_nettype none
module adsp_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clock,
  input  wire             reset_n,
  // filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_reg;
  reg [AW-1:0]    rd_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // honest full and empty from the fill count
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_reg];

  // pointers and count
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_reg    <= {AW{1'b0}};
      rd_reg    <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

  // storage, written only on a taken push
  always @(posedge clock) begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
endmodule
`default_nettype wire

//--- src/adsp_ctrl.v
`include "adsp_regs.vh"
`default_nettype none
module adsp_ctrl (
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // converter control 1
  input  wire        module_on,
  input  wire [2:0]  conversion_trigger_source,
  input  wire        auto_sample_enable,
  input  wire        simultaneous_sample_select,
  input  wire        sample_bit,
  // converter control 2
  input  wire [1:0]  sample_hold_channel_count,
  input  wire [3:0]  samples_per_interrupt,
  // converter control 3
  input  wire [4:0]  auto_sample_time,
  input  wire [5:0]  conv_clock_divider,
  input  wire        rc_clock_select,
  // system
  input  wire        sleep_req,
  input  wire        conv_int_enable,
  input  wire        ext_trigger,
  // sample-and-hold inputs from the analog front end
  input  wire [39:0] hold_in,
  // status
  output wire        module_active,
  output wire        sampling,
  output wire        converting,
  output reg         conv_done_reg,
  output reg         conv_event_reg,
  output reg         wake_reg,
  output reg  [9:0]  result_buffer_reg,
  // result stream
  output wire        result_valid,
  input  wire        result_ready,
  output wire [9:0]  result_data,
  output wire [1:0]  result_channel
);
  localparam ST_OFF     = 3'h0;
  localparam ST_WAIT    = 3'h1;
  localparam ST_IDLE    = 3'h2;
  localparam ST_SAMPLE  = 3'h3;
  localparam ST_DELAY   = 3'h4;
  localparam ST_CONVERT = 3'h5;
  localparam ST_STORE   = 3'h6;
  localparam integer RC_TAD_I = `ADSP_RC_TAD_CLKS;
  localparam integer TCY_I    = `ADSP_TCY_CLKS - 1;
  localparam [6:0] RC_TAD     = RC_TAD_I[6:0];
  localparam [1:0] TCY_LAST   = TCY_I[1:0];

  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [6:0] div_reg;
  reg  [4:0] tads_reg;
  reg  [1:0] chan_reg;
  reg  [1:0] dly_reg;
  reg  [3:0] samples_per_interrupt_reg;
  reg        trig_pend_reg;
  reg        sample_bit_d_reg;
  reg        off_seen_reg;
  reg        pd_reg;
  wire       clocks_run;
  wire [6:0] tad_period;
  wire       tad_tick;
  wire       sample_bit_rise;
  wire       sample_bit_fall;
  wire       trig_hit;
  wire [4:0] auto_sample_time_min;
  wire [1:0] last_chan;
  wire       fifo_in_ready;
  wire       enabled;
  wire       store_go;
  wire       group_event;
  wire [39:0] held_flat;
  wire [9:0] held_cur;

  // number of the last sample-and-hold channel in a group
  function [1:0] last_of;
    input [1:0] code;
    begin
      if (code == `ADSP_SAMPLE_HOLD_CHANNEL_COUNT_ONE)
        last_of = 2'h0;
      else if (code == `ADSP_SAMPLE_HOLD_CHANNEL_COUNT_TWO)
        last_of = 2'h1;
      else
        last_of = 2'h3;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // converter clock
  ////////////////////////////////////////////////////////////////////////////

  // module clocks stop in sleep unless the rc clock is chosen
  assign clocks_run = ~sleep_req | rc_clock_select;
  // period of (divider+1) clocks, or RC_TAD clocks with the rc clock, each clock half an instruction cycle
  assign tad_period = rc_clock_select ? RC_TAD : {1'b0, conv_clock_divider} + 7'h01;
  assign tad_tick   = clocks_run & (div_reg == tad_period - 7'h01);
  assign enabled    = module_on & ~pd_reg;
  assign module_active = enabled;

  // divider counter, held at zero while stopped; restarted on each state change so every phase counts whole periods
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 7'h00;
    end else if (!enabled || !clocks_run || tad_tick || state_reg == ST_OFF || state_next != state_reg) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  ////////////////////////////////////////////////////////////////////////////

  assign sample_bit_rise = sample_bit & ~sample_bit_d_reg;
  assign sample_bit_fall = ~sample_bit & sample_bit_d_reg;
  // zero sample time still samples for one period
  assign auto_sample_time_min  = (auto_sample_time == 5'h00) ? `ADSP_MIN_SAMPLE_TADS : auto_sample_time;
  assign last_chan = last_of(sample_hold_channel_count);
  // a request is honoured only after the least sampling time
  assign trig_hit  = (trig_pend_reg || (conversion_trigger_source == `ADSP_TRIG_AUTO &&
                     tads_reg >= auto_sample_time_min)) && tads_reg >= `ADSP_MIN_SAMPLE_TADS;
  assign sampling   = (state_reg == ST_SAMPLE);
  assign converting = (state_reg == ST_DELAY) | (state_reg == ST_CONVERT);

  // next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (enabled)
          state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (tads_reg >= `ADSP_WAKE_WAIT_TADS)
          state_next = ST_IDLE;
      end
      ST_IDLE: begin
        if (clocks_run && (auto_sample_enable || sample_bit_rise))
          state_next = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        if (trig_hit)
          state_next = rc_clock_select ? ST_DELAY : ST_CONVERT;
      end
      ST_DELAY: begin
        if (dly_reg == TCY_LAST)
          state_next = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (tads_reg == `ADSP_CONV_TADS)
          state_next = ST_STORE;
      end
      ST_STORE: begin
        if (fifo_in_ready) begin
          if (chan_reg != last_chan)
            state_next = ST_CONVERT;
          else if (auto_sample_enable)
            state_next = ST_SAMPLE;
          else
            state_next = ST_IDLE;
        end
      end
      default: state_next = ST_OFF;
    endcase
    // sleep without its own clock aborts sampling and conversion
    if (state_reg >= ST_SAMPLE && !clocks_run)
      state_next = ST_IDLE;
    // a sleep completion with no interrupt powers down at once
    if (group_event && sleep_req && off_seen_reg && !conv_int_enable)
      state_next = ST_OFF;
    // switching off wins over any trigger
    if (!enabled)
      state_next = ST_OFF;
  end

  // state, period counter and trigger bookkeeping
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= ST_OFF;
      tads_reg      <= 5'h00;
      chan_reg      <= 2'h0;
      dly_reg       <= 2'h0;
      trig_pend_reg <= 1'b0;
      sample_bit_d_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      sample_bit_d_reg <= sample_bit;
      if (state_next != state_reg)
        tads_reg <= 5'h00;
      else if (tad_tick && tads_reg != 5'h1F)
        tads_reg <= tads_reg + 5'h01;
      dly_reg <= (state_reg == ST_DELAY) ? dly_reg + 2'h1 : 2'h0;
      // conversion requests collected while sampling
      if (state_reg != ST_SAMPLE || state_next != ST_SAMPLE)
        trig_pend_reg <= 1'b0;
      else if ((conversion_trigger_source == `ADSP_TRIG_MANUAL && sample_bit_fall) ||
               (conversion_trigger_source != `ADSP_TRIG_MANUAL &&
                conversion_trigger_source != `ADSP_TRIG_AUTO && ext_trigger))
        trig_pend_reg <= 1'b1;
      if (state_reg == ST_SAMPLE)
        chan_reg <= 2'h0;
      else if (state_reg == ST_STORE && fifo_in_ready)
        chan_reg <= chan_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample and hold
  ////////////////////////////////////////////////////////////////////////////

  // each channel tracks its input until its hold moment
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_hold
      wire      grab_all;
      wire      grab_one;
      reg [9:0] held_reg;
      // simultaneous mode holds every channel when sampling ends
      assign grab_all = simultaneous_sample_select && state_reg == ST_SAMPLE && state_next != ST_SAMPLE;
      // sequential mode holds a channel as its own conversion starts
      assign grab_one = !simultaneous_sample_select && state_reg != ST_CONVERT &&
                        state_next == ST_CONVERT && (state_reg == ST_STORE ? chan_reg + 2'h1 : 2'h0) == gi;
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n)
          held_reg <= 10'h000;
        else if (grab_all || grab_one)
          held_reg <= hold_in[gi*10 +: 10];
      end
      assign held_flat[gi*10 +: 10] = held_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // completion, done flag and sleep outcome
  ////////////////////////////////////////////////////////////////////////////

  // held value of the channel being stored
  assign held_cur    = held_flat[chan_reg*10 +: 10];
  // nothing is stored while the clocks are stopped, so sleep leaves the result buffer, done flag and group count as they were
  assign store_go    = (state_reg == ST_STORE) & fifo_in_ready & enabled & clocks_run;
  assign group_event = store_go & (samples_per_interrupt_reg == samples_per_interrupt);

  // done flag set on each stored result; set wins over clear on a new sample
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_done_reg     <= 1'b0;
      result_buffer_reg <= `ADSP_RESULT_RST;
      samples_per_interrupt_reg          <= 4'h0;
      conv_event_reg    <= 1'b0;
      wake_reg          <= 1'b0;
    end else begin
      if (store_go) begin
        conv_done_reg     <= 1'b1;
        result_buffer_reg <= held_cur;
      end else if (state_reg != ST_SAMPLE && state_next == ST_SAMPLE) begin
        conv_done_reg <= 1'b0;
      end
      if (!module_on)
        samples_per_interrupt_reg <= 4'h0;
      else if (group_event)
        samples_per_interrupt_reg <= 4'h0;
      else if (store_go)
        samples_per_interrupt_reg <= samples_per_interrupt_reg + 4'h1;
      conv_event_reg <= group_event;
      wake_reg       <= group_event & sleep_req & conv_int_enable;
    end
  end

  // power down after a sleep completion with no interrupt; settings untouched
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      off_seen_reg <= 1'b0;
    else
      off_seen_reg <= module_on;
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      pd_reg <= 1'b0;
    else if (!sleep_req || !off_seen_reg)
      pd_reg <= 1'b0;
    else if (group_event && !conv_int_enable)
      pd_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // result buffer path
  ////////////////////////////////////////////////////////////////////////////

  // a full buffer holds the sequencer in the store state
  adsp_fifo #(
    .WIDTH (`ADSP_FIFO_W),
    .DEPTH (`ADSP_FIFO_DEPTH),
    .AW    (`ADSP_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (store_go),
    .in_ready  (fifo_in_ready),
    .in_data   ({chan_reg, held_cur}),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  ({result_channel, result_data})
  );
endmodule
`default_nettype wire

//--- verification/adsp_ctrl_checker.sv
`include "adsp_regs.vh"
`default_nettype none
module adsp_ctrl_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       reset_n,
  // controls
  input wire logic       module_on,
  input wire logic [2:0] conversion_trigger_source,
  input wire logic [4:0] auto_sample_time,
  input wire logic [5:0] conv_clock_divider,
  input wire logic       rc_clock_select,
  input wire logic       sleep_req,
  input wire logic       conv_int_enable,
  // status
  input wire logic       module_active,
  input wire logic       sampling,
  input wire logic       converting,
  input wire logic       conv_done_reg,
  input wire logic       conv_event_reg,
  input wire logic       wake_reg,
  input wire logic [9:0] result_buffer_reg,
  input wire logic       result_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sample_bit_run_reg;
  logic [15:0] conv_run_reg;
  logic [15:0] tad_clks;
  logic [15:0] auto_sample_time_tads;
  logic        live;
  // converter period in clocks, effective sample length, clocks not stopped
  assign tad_clks  = rc_clock_select ? 16'(`ADSP_RC_TAD_CLKS) : {10'h000, conv_clock_divider} + 16'h0001;
  assign auto_sample_time_tads = (auto_sample_time == 5'h00) ? 16'h0001 : {11'h000, auto_sample_time};
  assign live      = module_active && !(sleep_req && !rc_clock_select);
  // run lengths of the sample and convert phases
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sample_bit_run_reg <= 16'h0000;
      conv_run_reg <= 16'h0000;
    end else begin
      sample_bit_run_reg <= sampling ? sample_bit_run_reg + 16'h0001 : 16'h0000;
      conv_run_reg <= converting ? conv_run_reg + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // a phase that ended on its own, not by an abort
  sequence s_sample_done;
    $fell(sampling) && $past(live);
  endsequence
  sequence s_convert_done;
    $fell(converting) && $past(live);
  endsequence
  AST_OFF_INACTIVE: assert property (!module_on |-> !module_active)
    else $error("module active while switched off");
  AST_OFF_STOPS: assert property (!module_on |=> !sampling && !converting)
    else $error("sequencing continues while switched off");
  AST_SAMPLE_MIN: assert property (s_sample_done |-> sample_bit_run_reg >= tad_clks)
    else $error("sample phase shorter than one period");
  AST_AUTO_SAMPLE: assert property (s_sample_done ##0 conversion_trigger_source == 3'h7 |-> sample_bit_run_reg >= auto_sample_time_tads * tad_clks)
    else $error("auto sample phase shorter than programmed");
  AST_SAMPLE_TO_CONVERT: assert property (s_sample_done |-> converting)
    else $error("sample end not followed by conversion");
  AST_CONV_LEN: assert property (s_convert_done |-> conv_run_reg >= 16'(`ADSP_CONV_TADS) * tad_clks)
    else $error("conversion shorter than twelve periods");
  AST_DONE_EVENT: assert property (conv_event_reg |-> conv_done_reg)
    else $error("group event without done flag");
  AST_STORE_VALID: assert property ($rose(conv_done_reg) |-> result_valid)
    else $error("done flag without stored result");
  AST_BUF_ON_STORE: assert property (!$stable(result_buffer_reg) |-> conv_done_reg)
    else $error("result buffer changed without done flag");
  AST_WAKE: assert property (wake_reg |-> conv_event_reg && $past(sleep_req) && $past(conv_int_enable))
    else $error("wake without enabled completion in sleep");
  AST_SLEEP_ABORT: assert property (sleep_req && !rc_clock_select |=> !sampling && !converting)
    else $error("sequencing continues in sleep");
  AST_SLEEP_HOLD: assert property ($past(sleep_req) && !$past(rc_clock_select) |-> $stable(result_buffer_reg))
    else $error("result buffer changed in sleep");
endmodule
bind adsp_ctrl adsp_ctrl_checker u_chk (.clock, .reset_n, .module_on, .conversion_trigger_source,
  .auto_sample_time, .conv_clock_divider, .rc_clock_select, .sleep_req, .conv_int_enable, .module_active,
  .sampling, .converting, .conv_done_reg, .conv_event_reg, .wake_reg, .result_buffer_reg, .result_valid);
`default_nettype wire

//--- verification/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // design inputs
  logic        clock, reset_n, module_on, auto_sample_enable, sample_bit, simultaneous_sample_select;
  logic        rc_clock_select, sleep_req, conv_int_enable, ext_trigger, result_ready;
  logic [2:0]  conversion_trigger_source;
  logic [1:0]  sample_hold_channel_count;
  logic [3:0]  samples_per_interrupt;
  logic [4:0]  auto_sample_time;
  logic [5:0]  conv_clock_divider;
  logic [39:0] hold_in;
  // design outputs
  logic        module_active, sampling, converting, conv_done_reg, conv_event_reg, wake_reg, result_valid;
  logic [9:0]  result_buffer_reg, result_data;
  logic [1:0]  result_channel;
  logic [6:0]  st;
  int          n_errors, n_tests;
  assign st = {sampling, module_active, wake_reg, conv_event_reg, result_valid, converting, conv_done_reg};
  adsp_ctrl uut (.clock, .reset_n, .module_on, .conversion_trigger_source, .auto_sample_enable,
    .simultaneous_sample_select, .sample_bit, .sample_hold_channel_count, .samples_per_interrupt,
    .auto_sample_time, .conv_clock_divider, .rc_clock_select, .sleep_req, .conv_int_enable, .ext_trigger,
    .hold_in, .module_active, .sampling, .converting, .conv_done_reg, .conv_event_reg, .wake_reg,
    .result_buffer_reg, .result_valid, .result_ready, .result_data, .result_channel);
  // free-running clock
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bounded wait for one status bit
  task automatic wt(input int b, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge clock);
      if (st[b] === v) return;
    end
    n_errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, st[b], v);
    tally_and_finish();
  endtask
  // switch off, program, switch on
  task automatic start(input logic [2:0] tr, input logic [1:0] cp, input logic r);
    module_on = 0;
    repeat (3) @(negedge clock);
    conversion_trigger_source = tr;
    auto_sample_enable = (tr != 3'h0);
    sample_hold_channel_count = cp;
    samples_per_interrupt = (cp == 2'h0) ? 4'h0 : (cp == 2'h1) ? 4'h1 : 4'h3;
    rc_clock_select = r;
    module_on = 1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one auto group per channel count, words in channel order
  task automatic t_chan(input logic [1:0] cp, input int n);
    int k;
    start(3'h7, cp, 1'b0);
    for (k = 0; k < n; k++) begin
      wt(2, 1'b1, 400);
      chk(16'(result_channel), 16'(k));
      chk(16'(result_data), 16'(hold_in[k*10 +: 10]));
      chk(16'(result_buffer_reg), 16'(hold_in[k*10 +: 10]));
      chk(16'(conv_event_reg), 16'(k == n - 1));
    end
  endtask
  // software-timed sample held while the sample bit stays up
  task automatic t_manual();
    hold_in[9:0] = 10'h155;
    start(3'h0, 2'h0, 1'b0);
    repeat (10) @(negedge clock);
    chk(16'(sampling), 16'h0000);
    sample_bit = 1;
    wt(6, 1'b1, 10);
    repeat (8) @(negedge clock);
    chk(16'({sampling, converting}), 16'h0002);
    sample_bit = 0;
    wt(1, 1'b1, 10);
    wt(0, 1'b1, 100);
    chk(16'(result_buffer_reg), 16'h0155);
  endtask
  // stall the drain until the buffer refuses, then count what it held
  task automatic t_full();
    int c;
    c = 0;
    result_ready = 0;
    start(3'h7, 2'h0, 1'b0);
    repeat (600) @(negedge clock);
    module_on = 0;
    result_ready = 1;
    repeat (20) begin
      if (result_valid === 1'b1) c++;
      @(negedge clock);
    end
    chk(16'(c), 16'h0008);
  endtask
  // sleep or switch-off in mid-conversion: no store, buffer kept
  task automatic t_abort(input logic s);
    logic [9:0] kept;
    start(3'h7, 2'h0, 1'b0);
    wt(1, 1'b1, 100);
    kept = result_buffer_reg;
    if (s) sleep_req = 1;
    else module_on = 0;
    repeat (2) @(negedge clock);
    chk(16'({sampling, converting}), 16'h0000);
    chk(16'(module_active), 16'(s));
    repeat (40) @(negedge clock);
    chk(16'(conv_done_reg), 16'h0000);
    chk(16'(result_buffer_reg), 16'(kept));
    sleep_req = 0;
    module_on = 1;
    wt(0, 1'b1, 400);
    chk(16'(result_buffer_reg), 16'h0155);
  endtask
  // internal clock converts in sleep; wake only when enabled
  task automatic t_rc();
    hold_in[9:0] = 10'h2AA;
    start(3'h7, 2'h0, 1'b1);
    conv_int_enable = 1;
    sleep_req = 1;
    wt(4, 1'b1, 2000);
    chk(16'(conv_event_reg), 16'h0001);
    chk(16'(result_buffer_reg), 16'h02AA);
    conv_int_enable = 0;
    wt(5, 1'b0, 2000);
    chk(16'({sampling, converting}), 16'h0000);
    sleep_req = 0;
    wt(5, 1'b1, 50);
  endtask
  // other trigger sources: sampling lasts until the external pulse
  task automatic t_ext();
    hold_in[9:0] = 10'h0CD;
    start(3'h1, 2'h0, 1'b0);
    wt(6, 1'b1, 50);
    repeat (20) @(negedge clock);
    chk(16'({sampling, converting}), 16'h0002);
    ext_trigger = 1;
    @(negedge clock);
    ext_trigger = 0;
    wt(1, 1'b1, 10);
    wt(0, 1'b1, 100);
    chk(16'(result_buffer_reg), 16'h00CD);
  endtask
  // simultaneous holds both channels at sample end; sequential lets channel 1 track on
  task automatic t_hold(input logic sim);
    simultaneous_sample_select = sim;
    hold_in[19:10] = 10'h1A2;
    start(3'h7, 2'h1, 1'b0);
    wt(1, 1'b1, 100);
    hold_in[19:10] = 10'h0F0;
    wt(3, 1'b1, 400);
    chk(16'(result_channel), 16'h0001);
    chk(16'(result_data), sim ? 16'h01A2 : 16'h00F0);
    chk(16'(result_buffer_reg), sim ? 16'h01A2 : 16'h00F0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    n_tests = 0;
    {reset_n, module_on, auto_sample_enable, sample_bit, simultaneous_sample_select} = 5'h00;
    {rc_clock_select, sleep_req, conv_int_enable, ext_trigger} = 4'h0;
    result_ready = 1;
    conversion_trigger_source = 3'h7;
    sample_hold_channel_count = 2'h0;
    samples_per_interrupt = 4'h0;
    auto_sample_time = 5'h02;
    conv_clock_divider = 6'h01;
    hold_in = {10'h3C4, 10'h2B3, 10'h1A2, 10'h091};
    repeat (2) @(negedge clock);
    chk(16'({conv_done_reg, conv_event_reg, wake_reg, result_valid, module_active}), 16'h0000);
    chk(16'(result_buffer_reg), 16'h0000);
    reset_n = 1;
    t_chan(2'h0, 1);
    t_chan(2'h1, 2);
    t_chan(2'h2, 4);
    t_chan(2'h3, 4);
    t_manual();
    t_full();
    t_abort(1'b1);
    t_abort(1'b0);
    t_rc();
    t_ext();
    t_hold(1'b0);
    t_hold(1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
